// >>> rtl/spcc_ctrl.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spcc_params.svh"
// Summary of operation
// - clear, set, invert aliases at 4, 8, c
// - framed enable uses select pin as sync
// - sync direction: one input, zero output
// - polarity bit sets select/sync active level
// - controller drives select during each transfer
// - pulse width: one character or one clock
// - frame count codes 0-5 give two to the n
// - baud source: reference or bus clock
// - baud source, deep buffer writable only off
// - edge bit: sync with or before first
// - deep buffer bit selects multi-entry buffering
// - enable bit runs whole interface
// - idle halt stops module in idle
// - release bit frees serial out pin
// - audio mode forces clock polarity one
// - audio widths 24/32/16 in 64-bit frame
// - audio code zero: narrow, 32-bit frame
// - unimplemented bits read zero, reset zero
// - controller bit makes device clock master
// - polarity bit sets clock idle level
// - transmit irq mode codes held as written
// - receive irq mode codes held as written
module spcc_ctrl
   import spcc_pkg::*;
(
   input  wire logic        pclk,          // bus clock
   input  wire logic        presetn,       // async reset, active low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb access phase
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        idle_req,      // device idle mode, async
   input  wire logic        xfer_busy,     // transmission in progress
   input  wire logic        char_done,     // one character finished
   input  wire logic        bit_tick,      // serial clock period pulse
   input  wire logic        sync_in,       // select pin input, async
   output logic             sync_out,      // select pin output level
   output logic             sync_oe,       // select pin enable
   output logic             sdo_oe,        // module owns serial out pin
   output logic             sck_idle_lvl,  // effective clock idle level
   output logic             clk_master,    // device makes serial clock
   output logic             baud_ref_sel,  // baud from reference clock
   output logic             deep_buf,      // multi-entry buffering
   output logic             run_en,        // interface running
   output logic      [5:0]  word_bits,     // data bits per word
   output logic             frame_start    // sync pulse seen/sent
);
   logic [31:0] ctrl_q;      // control word
   logic [31:0] ctrl_d;      // next control word
   logic [31:0] stat_q;      // audio control word
   logic [31:0] stat_d;      // next audio word
   logic        idle_s;      // synchronised idle request
   logic        sync_s;      // synchronised select input
   logic        sync_s_q;    // previous sync level
   logic        run;         // module active
   logic        audio;       // audio mode on
   logic        fs_act;      // active sync level
   logic [5:0]  chr_cnt_q;   // characters since pulse
   logic [5:0]  chr_lim;     // characters per pulse
   logic        pulse_q;     // generated pulse asserted
   logic        acc;         // apb access edge
   logic        wr;          // write edge
   spcc_st_e    st_q;        // frame generator state

   // idle and select pins are asynchronous
   spcc_sync u_idle (
      .pclk   (pclk),
      .presetn(presetn),
      .d      (idle_req),
      .q      (idle_s)
   );
   spcc_sync u_fsin (
      .pclk   (pclk),
      .presetn(presetn),
      .d      (sync_in),
      .q      (sync_s)
   );

   // decode alias operation from address offset
   function automatic spcc_wr_e alias_op(input logic [3:0] off);
      if (off == 4'(`SPCC_OFF_CLR)) begin
         alias_op = SPCC_WR_CLR;
      end else if (off == 4'(`SPCC_OFF_SET)) begin
         alias_op = SPCC_WR_SET;
      end else if (off == 4'(`SPCC_OFF_INV)) begin
         alias_op = SPCC_WR_INV;
      end else begin
         alias_op = SPCC_WR_PLAIN;
      end
   endfunction : alias_op

   // apply an alias write to an old word
   function automatic logic [31:0] apply(input spcc_wr_e op,
                                         input logic [31:0] old,
                                         input logic [31:0] w);
      case (op)
         SPCC_WR_CLR: apply = old & ~w;
         SPCC_WR_SET: apply = old | w;
         SPCC_WR_INV: apply = old ^ w;
         default:     apply = w;
      endcase
   endfunction : apply

   // legal register offsets
   function automatic logic hit(input logic [11:0] a);
      hit = (a[11:5] == 7'h00) && (a[1:0] == 2'b00);
   endfunction : hit

   assign acc = psel && penable;
   assign wr  = acc && pwrite && hit(paddr);

   // next control word: mask, aliases, locked bits
   always_comb begin
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      if (wr && (paddr[4] == 1'b0)) begin
         ctrl_d = apply(alias_op(paddr[3:0]), ctrl_q, pwdata)
                  & `SPCC_CTRL_MASK;
         if (ctrl_q[`SPCC_B_ON]) begin
            // locked while enabled
            ctrl_d[`SPCC_B_BSRC] = ctrl_q[`SPCC_B_BSRC];
            ctrl_d[`SPCC_B_DEEP] = ctrl_q[`SPCC_B_DEEP];
         end
      end
      if (wr && (paddr[4] == 1'b1)) begin
         stat_d = apply(alias_op(paddr[3:0]), stat_q, pwdata)
                  & `SPCC_STAT_MASK;
      end
   end

   // control word register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SPCC_CTRL_RST;
         stat_q <= `SPCC_STAT_RST;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
      end
   end

   // apb answer: zero wait, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit(paddr);
         if (psel && !penable && !pwrite && hit(paddr)) begin
            if (paddr[4] == 1'b0) begin
               prdata <= ctrl_q;
            end else begin
               prdata <= stat_q;
            end
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   assign audio  = stat_q[0];
   // enable gated by idle halt
   assign run    = ctrl_q[`SPCC_B_ON] &&
                   !(ctrl_q[`SPCC_B_IDLE] && idle_s);
   assign fs_act = ctrl_q[`SPCC_B_FPOL];

   // characters per sync pulse
   always_comb begin
      case (ctrl_q[`SPCC_B_FCNT_H:`SPCC_B_FCNT_L])
         3'h0:    chr_lim = 6'h01;
         3'h1:    chr_lim = 6'h02;
         3'h2:    chr_lim = 6'h04;
         3'h3:    chr_lim = 6'h08;
         3'h4:    chr_lim = 6'h10;
         3'h5:    chr_lim = 6'h20;
         default: chr_lim = 6'h01; // reserved code
      endcase
   end

   // frame generator for master framed mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= SPCC_ST_IDLE;
         chr_cnt_q <= 6'h00;
         pulse_q   <= 1'b0;
      end else if (!run || !ctrl_q[`SPCC_B_FRAMED_MODE_ENABLE] ||
                   ctrl_q[`SPCC_B_FSDIR]) begin
         st_q      <= SPCC_ST_IDLE;
         chr_cnt_q <= 6'h00;
         pulse_q   <= 1'b0;
      end else begin
         case (st_q)
            SPCC_ST_IDLE: begin
               if (xfer_busy) begin
                  // edge bit picks early or coincident pulse
                  pulse_q <= 1'b1;
                  st_q    <= ctrl_q[`SPCC_B_FEDGE] ? SPCC_ST_RUN
                                                   : SPCC_ST_PRE;
               end
            end
            SPCC_ST_PRE: begin
               if (bit_tick) begin
                  st_q <= SPCC_ST_RUN;
               end
            end
            SPCC_ST_RUN: begin
               // short pulse ends after one clock period
               if (bit_tick && !ctrl_q[`SPCC_B_FPW]) begin
                  pulse_q <= 1'b0;
               end
               if (char_done) begin
                  pulse_q <= 1'b0;
                  if (chr_cnt_q + 6'h01 >= chr_lim) begin
                     chr_cnt_q <= 6'h00;
                     st_q      <= SPCC_ST_IDLE;
                  end else begin
                     chr_cnt_q <= chr_cnt_q + 6'h01;
                  end
               end
            end
            default: st_q <= SPCC_ST_IDLE;
         endcase
      end
   end

   // select pin drive and sync detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out    <= 1'b1;
         sync_oe     <= 1'b0;
         sync_s_q    <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         sync_s_q <= sync_s;
         if (run && ctrl_q[`SPCC_B_FRAMED_MODE_ENABLE]) begin
            // direction chooses input or output
            sync_oe     <= !ctrl_q[`SPCC_B_FSDIR];
            sync_out    <= pulse_q ? fs_act : !fs_act;
            frame_start <= ctrl_q[`SPCC_B_FSDIR]
                           ? (sync_s == fs_act && sync_s_q != fs_act)
                           : (xfer_busy && st_q == SPCC_ST_IDLE);
         end else if (run && ctrl_q[`SPCC_B_MST] &&
                      ctrl_q[`SPCC_B_ASSEL]) begin
            // auto select during each transmission
            sync_oe     <= 1'b1;
            sync_out    <= xfer_busy ? fs_act : !fs_act;
            frame_start <= 1'b0;
         end else begin
            sync_oe     <= 1'b0;
            sync_out    <= 1'b1;
            frame_start <= 1'b0;
         end
      end
   end

   // datapath steering outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_oe       <= 1'b0;
         sck_idle_lvl <= 1'b0;
         clk_master   <= 1'b0;
         baud_ref_sel <= 1'b0;
         deep_buf     <= 1'b0;
         run_en       <= 1'b0;
         word_bits    <= 6'h08;
      end else begin
         run_en       <= run;
         sdo_oe       <= run && !ctrl_q[`SPCC_B_SDOREL];
         sck_idle_lvl <= audio | ctrl_q[`SPCC_B_CKP];
         clk_master   <= ctrl_q[`SPCC_B_MST];
         baud_ref_sel <= ctrl_q[`SPCC_B_BSRC];
         deep_buf     <= ctrl_q[`SPCC_B_DEEP];
         case ({audio, ctrl_q[`SPCC_B_WIDE], ctrl_q[`SPCC_B_HALF]})
            3'h7:    word_bits <= 6'h18;
            3'h6:    word_bits <= 6'h20;
            3'h5:    word_bits <= 6'h10;
            3'h4:    word_bits <= 6'h10;
            3'h3:    word_bits <= 6'h20;
            3'h2:    word_bits <= 6'h20;
            3'h1:    word_bits <= 6'h10;
            default: word_bits <= 6'h08;
         endcase
      end
   end

   // locked baud source bit holds across writes while enabled
   property p_lock;
      @(posedge pclk) disable iff (!presetn)
      ctrl_q[`SPCC_B_ON] |=> $stable(ctrl_q[`SPCC_B_BSRC]);
   endproperty
   a_lock: assert property (p_lock)
      else $error("baud source changed while enabled");

   // reserved bits stay zero
   property p_resv;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q & ~`SPCC_CTRL_MASK) == 32'h0000_0000;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved control bit set");

   // audio forces clock idle high a cycle later
   property p_audck;
      @(posedge pclk) disable iff (!presetn)
      audio |=> sck_idle_lvl;
   endproperty
   a_audck: assert property (p_audck)
      else $error("clock polarity not forced in audio mode");

   // release bit frees serial out
   property p_sdo;
      @(posedge pclk) disable iff (!presetn)
      ctrl_q[`SPCC_B_SDOREL] |=> !sdo_oe;
   endproperty
   a_sdo: assert property (p_sdo)
      else $error("serial out driven while released");

   // auto select follows busy with chosen polarity
   property p_asel;
      @(posedge pclk) disable iff (!presetn)
      (run && !ctrl_q[`SPCC_B_FRAMED_MODE_ENABLE] && ctrl_q[`SPCC_B_MST] &&
       ctrl_q[`SPCC_B_ASSEL] && xfer_busy)
      |=> (sync_oe && sync_out == $past(fs_act));
   endproperty
   a_asel: assert property (p_asel)
      else $error("auto select not asserted");

   // input sync never drives the pin
   property p_fsin;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q[`SPCC_B_FRAMED_MODE_ENABLE] && ctrl_q[`SPCC_B_FSDIR]) |=> !sync_oe;
   endproperty
   a_fsin: assert property (p_fsin)
      else $error("select pin driven in sync input mode");

   // idle halt stops the module
   property p_idle;
      @(posedge pclk) disable iff (!presetn)
      (idle_s && ctrl_q[`SPCC_B_IDLE]) |=> !run_en;
   endproperty
   a_idle: assert property (p_idle)
      else $error("module running in idle with halt set");

   // set alias ors data into the control word
   property p_set;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SPCC_OFF_SET && !ctrl_q[`SPCC_B_ON])
      |=> ((ctrl_q & ($past(pwdata) & `SPCC_CTRL_MASK))
           == ($past(pwdata) & `SPCC_CTRL_MASK));
   endproperty
   a_set: assert property (p_set)
      else $error("set alias failed");
endmodule : spcc_ctrl
`default_nettype wire

// >>> rtl/spcc_params.svh
`ifndef SPCC_PARAMS_SVH
`define SPCC_PARAMS_SVH
// byte offsets of the control and status words and their aliases
`define SPCC_OFF_CTRL      12'h000
`define SPCC_OFF_CLR       12'h004
`define SPCC_OFF_SET       12'h008
`define SPCC_OFF_INV       12'h00c
`define SPCC_OFF_STAT      12'h010
`define SPCC_OFF_STAT_CLR  12'h014
`define SPCC_OFF_STAT_SET  12'h018
`define SPCC_OFF_STAT_INV  12'h01c
// control word field positions
`define SPCC_B_FRAMED_MODE_ENABLE   31
`define SPCC_B_FSDIR   30
`define SPCC_B_FPOL    29
`define SPCC_B_ASSEL   28
`define SPCC_B_FPW     27
`define SPCC_B_FCNT_H  26
`define SPCC_B_FCNT_L  24
`define SPCC_B_BSRC    23
`define SPCC_B_FEDGE   17
`define SPCC_B_DEEP    16
`define SPCC_B_ON      15
`define SPCC_B_IDLE    13
`define SPCC_B_SDOREL  12
`define SPCC_B_WIDE    11
`define SPCC_B_HALF    10
`define SPCC_B_CKP     6
`define SPCC_B_MST     5
// writable bits: 31:23, 17:15, 13:0
`define SPCC_CTRL_MASK 32'hff83_bfff
`define SPCC_CTRL_RST  32'h0000_0000
// status word: bit0 audio enable (writable)
`define SPCC_STAT_MASK 32'h0000_0001
`define SPCC_STAT_RST  32'h0000_0000
`endif

// >>> rtl/spcc_pkg.sv
package spcc_pkg;
   // alias operation of a write
   typedef enum logic [3:0] {
      SPCC_WR_PLAIN = 4'h1,
      SPCC_WR_CLR   = 4'h2,
      SPCC_WR_SET   = 4'h4,
      SPCC_WR_INV   = 4'h8
   } spcc_wr_e;
   // frame generator states
   typedef enum logic [2:0] {
      SPCC_ST_IDLE = 3'h1,
      SPCC_ST_PRE  = 3'h2,
      SPCC_ST_RUN  = 3'h4
   } spcc_st_e;
endpackage : spcc_pkg

// >>> rtl/spcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; change counts when stages two and three agree
module spcc_sync (
   input  wire logic pclk,    // bus clock
   input  wire logic presetn, // async reset, active low
   input  wire logic d,       // asynchronous level
   output logic      q        // filtered level
);
   logic s1_q; // first stage, read only by s2
   logic s2_q; // second stage
   logic s3_q; // third stage
   // shift chain and agreement filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q    <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end
endmodule : spcc_sync
`default_nettype wire

// >>> tb/spcc_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the port: shifter timing plus an external frame pulse source
module spcc_serial_model (
   input  wire logic pclk,      // bus clock
   input  wire logic presetn,   // async reset, active low
   input  wire logic go,        // keep a transfer running while high
   input  wire logic sync_pol,  // active level of the external pulse
   input  wire logic send_sync, // assert the external frame pulse
   output logic      xfer_busy, // transfer in progress
   output logic      bit_tick,  // one serial clock period
   output logic      char_done, // one character finished
   output logic      sync_in    // select pin level seen by the device
);
   logic       go_q;  // registered run request
   logic [4:0] cnt_q; // bit and character divider

   // divider runs only inside a transfer, so ticks stop between frames
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_q  <= 1'b0;
         cnt_q <= 5'h00;
      end else begin
         go_q  <= go;
         cnt_q <= go_q ? cnt_q + 5'h01 : 5'h00;
      end
   end

   // slave clocking from this side, eight ticks per character
   assign xfer_busy = go_q;
   assign bit_tick  = go_q && (cnt_q[1:0] == 2'h3);
   assign char_done = go_q && (cnt_q == 5'h1f);
   // pulse supplied by this party; idles at the inactive level
   assign sync_in   = send_sync ? sync_pol : ~sync_pol;
endmodule : spcc_serial_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// compare a design value with its expectation
`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
   end \
end
// let clocks pass until a condition holds, 40 cycles at most
`define WAITC(cond) begin \
   k = 0; \
   while (!(cond) && k < 40) begin \
      @(posedge pclk); \
      k++; \
   end \
end
module tb;
   logic        pclk, presetn, psel, penable, pwrite; // bus side
   logic [11:0] paddr;                // byte address
   logic [31:0] pwdata, prdata;       // write and read data
   logic        pready, pslverr;      // answer
   logic        idle_req, go, sync_pol, send_sync; // stimulus
   logic        xfer_busy, char_done, bit_tick, sync_in; // model
   logic        sync_out, sync_oe, sdo_oe, sck_idle_lvl; // pins
   logic        clk_master, baud_ref_sel, deep_buf, run_en;
   logic [5:0]  word_bits;            // word length
   logic        frame_start;          // frame pulse event
   logic [31:0] rdat;                 // last read data
   logic        rerr;                 // last error flag
   int          n_mismatch, checked, k, i;
   // expected word length, index = audio*4 + width code
   logic [5:0]  wb [8] = '{6'h08, 6'h10, 6'h20, 6'h20,
                           6'h10, 6'h10, 6'h20, 6'h18};

   spcc_ctrl spcc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .idle_req(idle_req), .xfer_busy(xfer_busy),
      .char_done(char_done), .bit_tick(bit_tick), .sync_in(sync_in),
      .sync_out(sync_out), .sync_oe(sync_oe), .sdo_oe(sdo_oe),
      .sck_idle_lvl(sck_idle_lvl), .clk_master(clk_master),
      .baud_ref_sel(baud_ref_sel), .deep_buf(deep_buf),
      .run_en(run_en), .word_bits(word_bits),
      .frame_start(frame_start));
   spcc_serial_model spcc_serial_model_i (.pclk(pclk),
      .presetn(presetn), .go(go), .sync_pol(sync_pol),
      .send_sync(send_sync), .xfer_busy(xfer_busy),
      .bit_tick(bit_tick), .char_done(char_done), .sync_in(sync_in));

   // 100 MHz bus clock
   always #5 pclk = ~pclk;

   // one bus transfer: setup, then access held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // read a word and compare it
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rdat, e)
      `CHK(rerr, 1'b0)
   endtask : rdc

   // print counts and verdict, then stop
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // hang guard, far beyond the expected run of a few hundred cycles
   initial begin
      #100us;
      n_mismatch++;
      finish_test();
   end

   // main sequence
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; idle_req = 0; go = 0;
      sync_pol = 0; send_sync = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(word_bits, 6'h08)
      rdc(12'h000, 32'h0000_0000);
      rdc(12'h010, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0000_0000);
      `CHK(rerr, 1'b1) // unmapped place
      // all ones: unimplemented bits stay clear, fields reach ports
      apb(1'b1, 12'h000, 32'hffff_ffff);
      rdc(12'h000, 32'hff83_bfff);
      `CHK(run_en, 1'b1)
      `CHK(baud_ref_sel, 1'b1)
      `CHK(deep_buf, 1'b1)
      `CHK(clk_master, 1'b1)
      `CHK(sdo_oe, 1'b0)
      `CHK(sck_idle_lvl, 1'b1)
      `CHK(word_bits, 6'h20)
      // clear while running keeps the locked bits
      apb(1'b1, 12'h004, 32'h0081_8000);
      // no access in the cycle right after disabling
      @(posedge pclk);
      rdc(12'h000, 32'hff83_3fff);
      `CHK(run_en, 1'b0)
      apb(1'b1, 12'h004, 32'h0081_0000);
      rdc(12'h000, 32'hff02_3fff);
      `CHK(baud_ref_sel, 1'b0)
      `CHK(deep_buf, 1'b0)
      // set and invert aliases
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0c60);
      rdc(12'h000, 32'h0000_0c60);
      apb(1'b1, 12'h00c, 32'h0000_8440);
      rdc(12'h000, 32'h0000_8820);
      `CHK(sdo_oe, 1'b1)
      `CHK(sck_idle_lvl, 1'b0)
      // every width code with audio off and on, clock polarity stored 0
      for (i = 0; i < 8; i++) begin
         apb(1'b1, 12'h010, {31'h0, i[2]});
         apb(1'b1, 12'h000, 32'h0000_8000 | (i[1:0] << 10));
         `WAITC(word_bits === wb[i])
         `CHK(word_bits, wb[i])
         `CHK(sck_idle_lvl, i[2])
         `CHK(clk_master, 1'b0)
      end
      apb(1'b1, 12'h014, 32'h0000_0001);
      // idle halt
      apb(1'b1, 12'h000, 32'h0000_a000);
      `WAITC(run_en === 1'b1)
      idle_req <= 1'b1;
      `WAITC(run_en === 1'b0)
      `CHK(run_en, 1'b0)
      apb(1'b1, 12'h000, 32'h0000_8000);
      `WAITC(run_en === 1'b1)
      `CHK(run_en, 1'b1)
      idle_req <= 1'b0;
      // framed controller, active high, one clock wide, edge bit 17 set
      apb(1'b1, 12'h000, 32'ha002_8020);
      `WAITC(sync_out === 1'b0)
      `CHK(sync_out, 1'b0)
      `CHK(sync_oe, 1'b1)
      go <= 1'b1;
      `WAITC(frame_start === 1'b1)
      `CHK(frame_start, 1'b1)
      `WAITC(sync_out === 1'b1)
      `CHK(sync_out, 1'b1)
      `WAITC(sync_out === 1'b0)
      `CHK(sync_out, 1'b0)
      go <= 1'b0;
      // framed target: pulse comes from the far side
      sync_pol <= 1'b1;
      apb(1'b1, 12'h000, 32'he002_8000);
      // pin drive follows the new setting one edge later
      `WAITC(sync_oe === 1'b0)
      `CHK(sync_oe, 1'b0)
      send_sync <= 1'b1;
      `WAITC(frame_start === 1'b1)
      `CHK(frame_start, 1'b1)
      send_sync <= 1'b0;
      // framed controller, character-wide pulse, early edge, every two
      apb(1'b1, 12'h000, 32'ha900_8020);
      go <= 1'b1;
      `WAITC(sync_out === 1'b1)
      `CHK(sync_out, 1'b1)
      repeat (8) @(posedge pclk);
      `CHK(sync_out, 1'b1)
      `WAITC(sync_out === 1'b0)
      `CHK(sync_out, 1'b0)
      repeat (16) @(posedge pclk);
      `CHK(sync_out, 1'b0)
      `WAITC(sync_out === 1'b1)
      `CHK(sync_out, 1'b1)
      go <= 1'b0;
      // automatic select, active low, in controller role
      apb(1'b1, 12'h000, 32'h1000_8020);
      `WAITC(sync_out === 1'b1)
      `CHK(sync_out, 1'b1)
      go <= 1'b1;
      `WAITC(sync_out === 1'b0)
      `CHK(sync_out, 1'b0)
      `CHK(sync_oe, 1'b1)
      go <= 1'b0;
      `WAITC(sync_out === 1'b1)
      `CHK(sync_out, 1'b1)
      // reset in mid-run brings every field back to zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(12'h000, 32'h0000_0000);
      `CHK(run_en, 1'b0)
      `CHK(sync_oe, 1'b0)
      finish_test();
   end
endmodule : tb
`default_nettype wire
